/* File: hw/cas_regs.vh */
/*
  constants for the card activation sequencer: register offsets, field
  positions, reset values and timing counts.
  assumes a classic wishbone slave with 32-bit data, 50 MHz system clock.
*/
// Behaviour
// - activation pin falling starts hardware activation
// - hardware activation clears line link disable
// - class pin picks 5V high, 3V low
// - clock enabled after supply settled, reset low
// - card reset follows host reset pin
// - auto timing counts clocks, releases reset
// - counter cleared on release, stops at start bit
// - data line ignored first 200 clocks
// - early answer fails, reset stays low, captured
// - answer before overflow completes, value captured
// - reset delay value resets to 400
// - overflow sets timeout flag, read clears it
// - warm reset: delay low time then high
// - auto timing off: pin follows reset bit
// - listed events start automatic deactivation
// - deactivation steps at 0, 5, 6, 7 units
// - deactivation runs uninterrupted to the end
// - software overcurrent set no deactivate; range does
// - reset and clock sources selected independently
// - address straps sampled at reset
// - power-down exits on reset or clear
// - supply select codes; nonzero starts converter
// - reset source picks bit or host pin
`ifndef CAS_REGS_VH
`define CAS_REGS_VH

// register byte offsets
`define CAS_CTRL_OFS     8'h00
`define CAS_CFG_OFS      8'h04
`define CAS_FLAG_OFS     8'h08
`define CAS_TIMER_OFS    8'h0C
`define CAS_CAPTURE_OFS  8'h10
`define CAS_STATUS_OFS   8'h14

// control register fields
`define CAS_CTRL_RST_BIT   0
`define CAS_CTRL_CLOCK_STOP_BIT    1
`define CAS_CTRL_LINKDIS   2
`define CAS_CTRL_DATALVL   3
`define CAS_CTRL_CKLVL     4
`define CAS_CTRL_ART       5
`define CAS_CTRL_PDN       6
`define CAS_CTRL_LP        7
`define CAS_CTRL_RESET     8'h06

// configuration register fields
`define CAS_CFG_RSTSEL     0
`define CAS_CFG_CKS_LO     1
`define CAS_CFG_IRQSEL     3
`define CAS_CFG_PRESPOL    4
`define CAS_CFG_RESET      5'h00

// flag register fields
`define CAS_FLAG_VSEL_LO   0
`define CAS_FLAG_RANGE     2
`define CAS_FLAG_OVERCUR   3
`define CAS_FLAG_TIMEOUT   5

// supply select codes
`define CAS_VSEL_OFF       2'h0
`define CAS_VSEL_1V8       2'h1
`define CAS_VSEL_3V        2'h2
`define CAS_VSEL_5V        2'h3

// clock source codes
`define CAS_CKS_STD        2'h0
`define CAS_CKS_CONV       2'h1
`define CAS_CKS_LEVEL      2'h2
`define CAS_CKS_HOST       2'h3

// timing
`define CAS_TIMER_RESET    16'h0190
`define CAS_IGNORE_CYC     16'h00C8
`define CAS_STEP_CONV_CYC  8
`define CAS_STEP_CLK_STOP  3'h5
`define CAS_STEP_DATA_LOW  3'h6
`define CAS_STEP_SUPPLY    3'h7

`endif

/* File: hw/cas_sequencer.v */
/*
  card activation sequencer: hardware and software activation, automatic
  reset transition, warm reset, self-timed deactivation, transparent
  selection and power-down state.
  assumes host and card pins are asynchronous to clk_i; converter clock
  and card supply status arrive as plain pins; wishbone master is classic.
*/
// Decided for this implementation: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "cas_regs.vh"

module cas_sequencer #(
  parameter TIMER_W = 16
) (
  // system
  input  wire               clk_i,
  input  wire               rst_i,
  // wishbone slave
  input  wire               cyc_i,
  input  wire               stb_i,
  input  wire               we_i,
  input  wire [7:0]         adr_i,
  input  wire [3:0]         sel_i,
  input  wire [31:0]        dat_i,
  output reg  [31:0]        dat_o,
  output wire               ack_o,
  output wire               err_o,
  // host side pins
  input  wire               activation_command_pin_i,
  input  wire               class_select_addr0_pin_i,
  input  wire               host_reset_addr1_pin_i,
  input  wire               host_clock_addr2_pin_i,
  input  wire               host_clk_i,
  // analog and monitor inputs
  input  wire               converter_clock_signal_i,
  input  wire               supply_settled_i,
  input  wire               overcurrent_i,
  input  wire               supply_range_err_i,
  input  wire               card_present_filtered_i,
  input  wire               power_fail_i,
  input  wire               reset_pin_low_i,
  // card side
  input  wire               card_data_line_i,
  output reg  [1:0]         card_supply_select_o,
  output reg                converter_on_o,
  output reg                card_clock_pin_o,
  output reg                card_reset_pin_o,
  output wire               line_link_disable_o,
  output wire               card_data_level_o,
  output wire               powered_down_o,
  output reg  [2:0]         bus_addr_low_o
);

  // two-stage synchronisers for twelve asynchronous inputs; reset_pin_low_i is used unsynchronised
  localparam NSYNC = 12;
  wire [NSYNC-1:0] async_w = {activation_command_pin_i, class_select_addr0_pin_i,
                              host_reset_addr1_pin_i, host_clock_addr2_pin_i,
                              host_clk_i, converter_clock_signal_i, supply_settled_i,
                              overcurrent_i, supply_range_err_i, card_present_filtered_i,
                              power_fail_i, card_data_line_i};
  reg  [NSYNC-1:0] meta_reg;
  reg  [NSYNC-1:0] sync_reg;
  reg  [NSYNC-1:0] prev_reg;
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
      always @(posedge clk_i) begin
        meta_reg[gi] <= async_w[gi];
        sync_reg[gi] <= meta_reg[gi];
        prev_reg[gi] <= sync_reg[gi];
      end
    end
  endgenerate

  wire cmd_s = sync_reg[11];
  wire cls_s = sync_reg[10];
  wire hrst_s = sync_reg[9];
  wire hck_s = sync_reg[8];
  wire hclk_s = sync_reg[7];
  wire converter_clock_signal_s = sync_reg[6];
  wire settled_s = sync_reg[5];
  wire ocur_s = sync_reg[4];
  wire range_s = sync_reg[3];
  wire present_s = sync_reg[2];
  wire pfail_s = sync_reg[1];
  wire cio_s = sync_reg[0];
  wire cmd_fall = prev_reg[11] & ~cmd_s;
  wire cmd_rise = ~prev_reg[11] & cmd_s;
  wire hrst_rise = ~prev_reg[9] & hrst_s;
  wire converter_clock_signal_rise = ~prev_reg[6] & converter_clock_signal_s;
  wire cio_fall = prev_reg[0] & ~cio_s;
  wire ocur_rise = ~prev_reg[4] & ocur_s;
  wire range_rise = ~prev_reg[3] & range_s;
  wire pres_fall = prev_reg[2] & ~present_s;
  wire pfail_rise = ~prev_reg[1] & pfail_s;

  // software visible and internal state
  reg  [7:0]         ctrl_reg;
  reg  [4:0]         cfg_reg;
  reg  [1:0]         vsel_reg;
  reg                range_flag_reg;
  reg                ocur_flag_reg;
  reg                timeout_flag_reg;
  reg  [TIMER_W-1:0] timer_reg;
  reg  [TIMER_W-1:0] capture_reg;
  reg  [TIMER_W-1:0] count_reg;
  reg                counting_reg;
  reg                ignore_done_reg;
  reg                released_reg;
  reg                art_prev_reg;
  reg                hw_act_reg;
  reg                hw_rst_linked_reg;
  reg                deact_reg;
  reg  [2:0]         step_reg;
  reg  [2:0]         sub_reg;
  reg                strap_done_reg;
  reg                ack_reg;

  wire rst_bit = ctrl_reg[`CAS_CTRL_RST_BIT];
  wire auto_reset_timing_enable = ctrl_reg[`CAS_CTRL_ART];
  wire rst_sel = cfg_reg[`CAS_CFG_RSTSEL];
  wire [1:0] card_clock_source_field = cfg_reg[`CAS_CFG_CKS_LO+1:`CAS_CFG_CKS_LO];

  // bus decode, one wait state: ack the cycle after the request
  wire req = cyc_i & stb_i & ~ack_reg;
  wire wr = req & we_i & sel_i[0];
  wire hit_ctrl = adr_i == `CAS_CTRL_OFS;
  wire hit_cfg = adr_i == `CAS_CFG_OFS;
  wire hit_flag = adr_i == `CAS_FLAG_OFS;
  wire hit_tmr = adr_i == `CAS_TIMER_OFS;
  wire hit_cap = adr_i == `CAS_CAPTURE_OFS;
  wire hit_st = adr_i == `CAS_STATUS_OFS;
  wire mapped = hit_ctrl | hit_cfg | hit_flag | hit_tmr | hit_cap | hit_st;
  assign ack_o = ack_reg & mapped;
  assign err_o = ack_reg & ~mapped;
  wire flag_read = req & ~we_i & hit_flag;

  // software range set deactivates, overcurrent set does not
  wire sw_range_set = wr & hit_flag & dat_i[`CAS_FLAG_RANGE];
  wire sw_pdn_set = wr & hit_ctrl & dat_i[`CAS_CTRL_PDN] & ~ctrl_reg[`CAS_CTRL_PDN];
  wire deact_trig = ocur_rise | range_rise | sw_range_set | pres_fall | sw_pdn_set |
                    cmd_rise | pfail_rise | reset_pin_low_i;
  wire step_tick = deact_reg & converter_clock_signal_rise & (sub_reg == 3'h7);
  wire [2:0] step_next = step_reg + 3'h1;

  // card clock: rising card clock edge found on the system clock
  reg  card_clock_pin_prev_reg;
  wire card_clock_pin_rise = card_clock_pin_o & ~card_clock_pin_prev_reg;

  wire atr_seen = counting_reg & ignore_done_reg & cio_fall;
  wire counter_full = count_reg == {TIMER_W{1'b1}};

  always @(posedge clk_i) begin
    if (rst_i) begin
      strap_done_reg <= 1'b0;
      bus_addr_low_o <= 3'h0;
    end else if (!strap_done_reg) begin
      strap_done_reg <= 1'b1;
      bus_addr_low_o <= {hck_s, hrst_s, cls_s};
    end
  end

  // bus acknowledge and read data
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_reg <= req;
      if (req & ~we_i) begin
        dat_o <= 32'h00000000;
        if (hit_ctrl) dat_o[7:0] <= ctrl_reg;
        if (hit_cfg) dat_o[4:0] <= cfg_reg;
        if (hit_flag) dat_o[5:0] <= {timeout_flag_reg, 1'b0, ocur_flag_reg,
                                     range_flag_reg, vsel_reg};
        if (hit_tmr) dat_o[TIMER_W-1:0] <= timer_reg;
        if (hit_cap) dat_o[TIMER_W-1:0] <= capture_reg;
        if (hit_st) dat_o[7:0] <= {deact_reg, hw_act_reg, counting_reg, settled_s,
                                   present_s, step_reg};
      end
    end
  end

  // control, sequencing and flags
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= `CAS_CTRL_RESET;
      cfg_reg <= `CAS_CFG_RESET;
      vsel_reg <= `CAS_VSEL_OFF;
      range_flag_reg <= 1'b0;
      ocur_flag_reg <= 1'b0;
      timeout_flag_reg <= 1'b0;
      timer_reg <= `CAS_TIMER_RESET;
      capture_reg <= {TIMER_W{1'b0}};
      count_reg <= {TIMER_W{1'b0}};
      counting_reg <= 1'b0;
      ignore_done_reg <= 1'b0;
      released_reg <= 1'b0;
      art_prev_reg <= 1'b0;
      hw_act_reg <= 1'b0;
      hw_rst_linked_reg <= 1'b0;
      deact_reg <= 1'b0;
      step_reg <= 3'h0;
      sub_reg <= 3'h0;
      card_clock_pin_prev_reg <= 1'b0;
    end else begin
      card_clock_pin_prev_reg <= card_clock_pin_o;
      art_prev_reg <= auto_reset_timing_enable;
      // register writes; sequence logic below overrides them
      if (wr & hit_ctrl) ctrl_reg <= dat_i[7:0];
      if (wr & hit_cfg) cfg_reg <= dat_i[4:0];
      if (wr & hit_flag) vsel_reg <= dat_i[`CAS_FLAG_VSEL_LO+1:`CAS_FLAG_VSEL_LO];
      if (wr & hit_tmr) timer_reg <= dat_i[TIMER_W-1:0];
      // flags: hardware set wins over read clear
      if (flag_read) begin
        range_flag_reg <= 1'b0;
        ocur_flag_reg <= 1'b0;
        timeout_flag_reg <= 1'b0;
      end
      if (wr & hit_flag & dat_i[`CAS_FLAG_RANGE]) range_flag_reg <= 1'b1;
      if (wr & hit_flag & dat_i[`CAS_FLAG_OVERCUR]) ocur_flag_reg <= 1'b1;
      if (wr & hit_flag & dat_i[`CAS_FLAG_TIMEOUT]) timeout_flag_reg <= 1'b1;
      if (range_rise) range_flag_reg <= 1'b1;
      if (ocur_rise) ocur_flag_reg <= 1'b1;

      // counter starts on reset bit set or warm reset
      // warm reset by setting auto timing
      if (auto_reset_timing_enable & ((wr & hit_ctrl & dat_i[`CAS_CTRL_RST_BIT] & ~rst_bit) |
                 (~art_prev_reg & rst_bit))) begin
        counting_reg <= 1'b1;
        count_reg <= {TIMER_W{1'b0}};
        ignore_done_reg <= 1'b0;
        released_reg <= 1'b0;
      end else if (counting_reg & auto_reset_timing_enable) begin
        if (card_clock_pin_rise) begin
          if (count_reg == `CAS_IGNORE_CYC - 16'h0001) ignore_done_reg <= 1'b1;
          if (!released_reg && count_reg == timer_reg - 16'h0001) begin
            released_reg <= 1'b1;
            count_reg <= {TIMER_W{1'b0}};
          end else if (counter_full) begin
            timeout_flag_reg <= 1'b1;
            counting_reg <= 1'b0;
          end else begin
            count_reg <= count_reg + 16'h0001;
          end
        end
        if (atr_seen) begin
          capture_reg <= count_reg;
          counting_reg <= 1'b0;
        end
      end else if (!auto_reset_timing_enable) begin
        counting_reg <= 1'b0;
      end

      if (cmd_fall & ~deact_reg) begin
        hw_act_reg <= 1'b1;
        hw_rst_linked_reg <= 1'b0;
        ctrl_reg[`CAS_CTRL_LINKDIS] <= 1'b0;
        vsel_reg <= cls_s ? `CAS_VSEL_5V : `CAS_VSEL_3V;
      end else if (hw_act_reg & ~deact_reg) begin
        if (settled_s & ~hrst_s) ctrl_reg[`CAS_CTRL_CLOCK_STOP_BIT] <= 1'b0;
        // reset linked once host pin low
        if (~hrst_s) hw_rst_linked_reg <= 1'b1;
      end

      if (deact_reg) begin
        if (converter_clock_signal_rise) sub_reg <= sub_reg + 3'h1;
        if (step_tick) begin
          step_reg <= step_next;
          if (step_next == `CAS_STEP_CLK_STOP) begin
            ctrl_reg[`CAS_CTRL_CKLVL] <= 1'b0;
            ctrl_reg[`CAS_CTRL_CLOCK_STOP_BIT] <= 1'b1;
            ctrl_reg[`CAS_CTRL_DATALVL] <= 1'b1;
            ctrl_reg[`CAS_CTRL_LINKDIS] <= 1'b1;
          end
          if (step_next == `CAS_STEP_DATA_LOW) ctrl_reg[`CAS_CTRL_DATALVL] <= 1'b0;
          if (step_next == `CAS_STEP_SUPPLY) begin
            vsel_reg <= `CAS_VSEL_OFF;
            deact_reg <= 1'b0;
          end
        end
      end else if (deact_trig & (vsel_reg != `CAS_VSEL_OFF)) begin
        deact_reg <= 1'b1;
        step_reg <= 3'h0;
        sub_reg <= 3'h0;
        hw_act_reg <= 1'b0;
        counting_reg <= 1'b0;
        ctrl_reg[`CAS_CTRL_RST_BIT] <= 1'b0;
        ctrl_reg[`CAS_CTRL_PDN] <= 1'b1;
      end
    end
  end

  // card reset pin source
  always @(posedge clk_i) begin
    if (rst_i) begin
      card_reset_pin_o <= 1'b0;
    end else if (deact_reg) begin
      card_reset_pin_o <= 1'b0;
    end else if (hw_act_reg) begin
      // rising host reset sets card reset
      if (hrst_rise) card_reset_pin_o <= 1'b1;
      else if (hw_rst_linked_reg) card_reset_pin_o <= hrst_s;
    end else if (rst_sel) begin
      card_reset_pin_o <= hrst_s;
    end else if (auto_reset_timing_enable) begin
      card_reset_pin_o <= released_reg;
    end else begin
      card_reset_pin_o <= rst_bit;
    end
  end

  // card clock and converter outputs
  always @(posedge clk_i) begin
    if (rst_i) begin
      card_clock_pin_o <= 1'b0;
      converter_on_o <= 1'b0;
      card_supply_select_o <= `CAS_VSEL_OFF;
    end else begin
      // converter runs for nonzero select with card
      converter_on_o <= (vsel_reg != `CAS_VSEL_OFF) & present_s;
      card_supply_select_o <= vsel_reg;
      if (ctrl_reg[`CAS_CTRL_CLOCK_STOP_BIT]) begin
        card_clock_pin_o <= ctrl_reg[`CAS_CTRL_CKLVL];
      end else begin
        case (card_clock_source_field)
          `CAS_CKS_STD:   card_clock_pin_o <= hclk_s;
          `CAS_CKS_CONV:  card_clock_pin_o <= converter_clock_signal_s;
          `CAS_CKS_LEVEL: card_clock_pin_o <= ctrl_reg[`CAS_CTRL_CKLVL];
          `CAS_CKS_HOST:  card_clock_pin_o <= hck_s;
          default:        card_clock_pin_o <= hclk_s;
        endcase
      end
    end
  end

  assign line_link_disable_o = ctrl_reg[`CAS_CTRL_LINKDIS];
  assign card_data_level_o = ctrl_reg[`CAS_CTRL_DATALVL];
  // power-down follows the request bit; registers retained
  assign powered_down_o = ctrl_reg[`CAS_CTRL_PDN];

endmodule // cas_sequencer

/* File: tb/cas_card_model.sv */
/*
  behavioural card and supply: settles the supply after the converter
  starts and sends one answer start bit a set number of card clocks in.
  assumes the data line has a pull-up, so it idles high.
*/
`timescale 1ns/1ps

module cas_card_model (
  // card contacts
  input  wire        card_clk_i,
  input  wire        card_rst_i,
  input  wire        conv_on_i,
  // scenario control: early answers while reset is still low
  input  wire        early_i,
  input  wire [15:0] dly_i,
  // answers
  output reg         settled_o,
  output wire        data_o
);
  reg [15:0] cnt_reg;

  initial cnt_reg = 16'h0000;
  initial settled_o = 1'b0;

  // supply takes 2 us to settle, a limitation: a quick off-on is not modelled
  always @(conv_on_i) begin
    if (conv_on_i)
      settled_o <= #2000 1'b1;
    else
      settled_o <= 1'b0;
  end

  always @(posedge card_clk_i) begin
    if (card_rst_i != early_i)
      cnt_reg <= cnt_reg + 16'h0001;
    else
      cnt_reg <= 16'h0000;
  end

  assign data_o = !(cnt_reg >= dly_i && cnt_reg < dly_i + 16'h0004);
endmodule // cas_card_model

/* File: tb/cas_seq_properties.sv */
/*
  concurrent checks on the sequencer's top-level ports: bus answer,
  address straps, hardware activation steps and deactivation.
  assumes one clock domain, sync active-high reset, classic wishbone master.
*/
`timescale 1ns/1ps

module cas_seq_properties (
  // system
  input wire       clk_i,
  input wire       rst_i,
  // bus
  input wire       cyc_i,
  input wire       stb_i,
  input wire [7:0] adr_i,
  input wire       ack_o,
  input wire       err_o,
  // host pins and monitors
  input wire       activation_command_pin_i,
  input wire       class_select_addr0_pin_i,
  input wire       host_reset_addr1_pin_i,
  input wire       host_clock_addr2_pin_i,
  input wire       power_fail_i,
  input wire       card_present_filtered_i,
  // card side
  input wire [1:0] card_supply_select_o,
  input wire       card_reset_pin_o,
  input wire       line_link_disable_o,
  input wire       card_data_level_o,
  input wire       powered_down_o,
  input wire [2:0] bus_addr_low_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // a request not yet answered
  wire req = cyc_i && stb_i && !ack_o && !err_o;

  // activation pin falls with a card present and the supply off
  sequence hw_start;
    $fell(activation_command_pin_i) && card_present_filtered_i &&
      card_supply_select_o == 2'h0;
  endsequence
  // first deactivation step lands within the synchroniser delay
  sequence deact_t0;
    ##[1:8] (!card_reset_pin_o && powered_down_o);
  endsequence

  bus_ack_a: assert property (req |=> ack_o ^ err_o)
    else $error("bus request not answered in one cycle");
  bus_err_a: assert property (req && adr_i > 8'h14 |=> err_o && !ack_o)
    else $error("unmapped address acknowledged");
  strap_latch_a: assert property ($fell(rst_i) |-> ##2 bus_addr_low_o ==
    {host_clock_addr2_pin_i, host_reset_addr1_pin_i, class_select_addr0_pin_i})
    else $error("address straps not latched");
  link_join_a: assert property (hw_start |-> ##[1:8] !line_link_disable_o)
    else $error("lines not joined at activation");
  class_pick_a: assert property (hw_start |-> ##[1:8]
    card_supply_select_o == {1'b1, class_select_addr0_pin_i})
    else $error("wrong supply class at activation");
  host_rst_a: assert property ($rose(host_reset_addr1_pin_i) &&
    !line_link_disable_o |-> ##[2:6] card_reset_pin_o)
    else $error("card reset did not follow host reset");
  deact_start_a: assert property (($rose(power_fail_i) ||
    $rose(activation_command_pin_i)) && card_supply_select_o != 2'h0 |-> deact_t0)
    else $error("deactivation did not start");
  deact_end_a: assert property ($fell(card_supply_select_o != 2'h0) |->
    line_link_disable_o && !card_data_level_o && powered_down_o)
    else $error("supply off before lines parked");
endmodule // cas_seq_properties

/* File: tb/cas_sequencer_tb.sv */
/*
  self-checking bench for the card activation sequencer, one task per scenario.
  assumes cas_regs.vh on the include path, checker and card model compiled first.
*/
`timescale 1ns/1ps
`include "cas_regs.vh"

module cas_sequencer_tb;
  reg         clk_i = 1'b0;
  reg         rst_i = 1'b1;
  reg         cyc = 1'b0;
  reg         stb = 1'b0;
  reg         we = 1'b0;
  reg  [7:0]  adr = 8'h00;
  reg  [3:0]  sel = 4'h0;
  reg  [31:0] dat = 32'h0;
  reg         act = 1'b1;
  reg         hrst = 1'b0;
  reg         hclk = 1'b0;
  reg         conv = 1'b0;
  reg         pfail = 1'b0;
  reg         ocur = 1'b0;
  reg         early = 1'b0;
  reg  [15:0] dly = 16'h0032;
  reg  [31:0] rdat;
  reg         berr;
  int         err_count = 0;
  int         n_compared = 0;
  int         n;
  wire [31:0] dat_o;
  wire        ack_o, err_o, settled, dline, conv_on, ccl, card_reset_pin, ldis, dlvl, pdn;
  wire [1:0]  vsel;
  wire [2:0]  straps;

  // system clock; card and converter clocks start off phase
  always #10 clk_i = ~clk_i;
  // host card clock held low while powered down
  initial begin #7; forever #80 hclk = ~hclk & ~pdn; end
  initial begin #3; forever #40 conv = ~conv; end

  cas_sequencer dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
    .activation_command_pin_i(act), .class_select_addr0_pin_i(1'b1),
    .host_reset_addr1_pin_i(hrst), .host_clock_addr2_pin_i(1'b1), .host_clk_i(hclk),
    .converter_clock_signal_i(conv), .supply_settled_i(settled), .overcurrent_i(ocur),
    .supply_range_err_i(1'b0), .card_present_filtered_i(1'b1), .power_fail_i(pfail),
    .reset_pin_low_i(1'b0), .card_data_line_i(dline), .card_supply_select_o(vsel),
    .converter_on_o(conv_on), .card_clock_pin_o(ccl), .card_reset_pin_o(card_reset_pin),
    .line_link_disable_o(ldis), .card_data_level_o(dlvl), .powered_down_o(pdn),
    .bus_addr_low_o(straps));

  cas_card_model card (.card_clk_i(ccl), .card_rst_i(card_reset_pin), .conv_on_i(conv_on),
    .early_i(early), .dly_i(dly), .settled_o(settled), .data_o(dline));

  task test_done;
    begin
      $display("compared %0d errors %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask

  // range compare; an unknown never lands inside the range
  task chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    begin
      n_compared = n_compared + 1;
      if ((got >= lo && got <= hi) !== 1'b1) begin
        err_count = err_count + 1;
        $display("[ERR] %0t got %h want %h..%h", $time, got, lo, hi);
      end
    end
  endtask

  // an exhausted wait ends the run
  task tmo(input int cnt, input int lim);
    if (cnt >= lim) begin
      err_count = err_count + 1;
      test_done;
    end
  endtask

  // classic cycle: ack sampled at a rising edge, data taken and request dropped there
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    begin
      @(posedge clk_i);
      {cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, 4'hF, d};
      k = 0;
      do begin
        @(posedge clk_i);
        k = k + 1;
      end while (ack_o !== 1'b1 && err_o !== 1'b1 && k < 16);
      tmo(k, 16);
      rdat = dat_o;
      berr = err_o;
      {cyc, stb, sel} <= 6'h00;
    end
  endtask

  task t_reset;
    begin
      wb(0, `CAS_CTRL_OFS, 0);
      chk(rdat, 32'h06, 32'h06);
      chk(straps, 3'h5, 3'h5);
      wb(0, `CAS_TIMER_OFS, 0);
      chk(rdat, 32'h190, 32'h190);
      wb(0, 8'h40, 0);
      chk(berr, 1, 1);
    end
  endtask

  task t_hw;
    begin
      wb(1, `CAS_CFG_OFS, 32'h09);
      @(posedge clk_i);
      act <= 1'b0;
      for (n = 0; n < 300 && ldis !== 1'b0; n++) @(negedge clk_i);
      chk(n, 2, 10);
      // supply select pin lags the internal choice by one cycle
      @(negedge clk_i);
      chk(vsel, 3, 3);
      for (n = 0; n < 300 && ccl !== 1'b1; n++) @(negedge clk_i);
      chk(n, 98, 125);
      chk(card_reset_pin, 0, 0);
      @(posedge clk_i);
      hrst <= 1'b1;
      for (n = 0; n < 20 && card_reset_pin !== 1'b1; n++) @(negedge clk_i);
      chk(n, 2, 8);
      @(posedge clk_i);
      pfail <= 1'b1;
      repeat (100) @(posedge clk_i);
      act <= 1'b1;
      pfail <= 1'b0;
      for (n = 0; n < 400 && vsel !== 2'h0; n++) @(negedge clk_i);
      chk(n + 100, 218, 240);
      wb(0, `CAS_CTRL_OFS, 0);
      chk(rdat, 32'h46, 32'h46);
    end
  endtask

  task t_sw;
    begin
      wb(1, `CAS_CFG_OFS, 32'h00);
      wb(1, `CAS_CTRL_OFS, 32'h06);
      chk(pdn, 0, 0);
      wb(1, `CAS_FLAG_OFS, 32'h02);
      @(negedge clk_i);
      chk(vsel, 2, 2);
      for (n = 0; n < 300 && settled !== 1'b1; n++) @(negedge clk_i);
      tmo(n, 300);
      wb(1, `CAS_CTRL_OFS, 32'h0E);
      wb(1, `CAS_CTRL_OFS, 32'h28);
      wb(1, `CAS_CTRL_OFS, 32'h29);
      for (n = 0; n < 4000 && card_reset_pin !== 1'b1; n++) @(negedge clk_i);
      chk(n, 3192, 3212);
      repeat (800) @(posedge clk_i);
      wb(0, `CAS_CAPTURE_OFS, 0);
      chk(rdat, 49, 51);
    end
  endtask

  task t_warm;
    begin
      early <= 1'b1;
      dly <= 16'd100;
      wb(1, `CAS_TIMER_OFS, 32'h012C);
      wb(1, `CAS_CTRL_OFS, 32'h09);
      repeat (4) @(posedge clk_i);
      chk(card_reset_pin, 1, 1);
      wb(1, `CAS_CTRL_OFS, 32'h29);
      for (n = 0; n < 40 && card_reset_pin !== 1'b0; n++) @(negedge clk_i);
      tmo(n, 40);
      for (n = 0; n < 3000 && card_reset_pin !== 1'b1; n++) @(negedge clk_i);
      chk(n, 2392, 2408);
    end
  endtask

  task t_early;
    begin
      dly <= 16'd300;
      wb(1, `CAS_TIMER_OFS, 32'h0190);
      wb(1, `CAS_CTRL_OFS, 32'h09);
      wb(1, `CAS_CTRL_OFS, 32'h29);
      repeat (4000) @(posedge clk_i);
      chk(card_reset_pin, 0, 0);
      wb(0, `CAS_CAPTURE_OFS, 0);
      chk(rdat, 299, 301);
    end
  endtask

  task t_flags;
    begin
      wb(1, `CAS_FLAG_OFS, 32'h2A);
      repeat (300) @(posedge clk_i);
      chk(vsel, 2, 2);
      wb(0, `CAS_FLAG_OFS, 0);
      chk(rdat, 32'h2A, 32'h2A);
      wb(0, `CAS_FLAG_OFS, 0);
      chk(rdat, 32'h02, 32'h02);
      wb(1, `CAS_FLAG_OFS, 32'h06);
      for (n = 0; n < 400 && vsel !== 2'h0; n++) @(negedge clk_i);
      chk(n, 212, 238);
      // hardware overcurrent with supply off only raises the flag
      @(posedge clk_i);
      ocur <= 1'b1;
      repeat (6) @(posedge clk_i);
      wb(0, `CAS_FLAG_OFS, 0);
      chk(rdat, 32'h0C, 32'h0C);
    end
  endtask

  task t_pdn;
    begin
      wb(1, `CAS_CTRL_OFS, 32'h80);
      wb(1, `CAS_CTRL_OFS, 32'hC0);
      chk(pdn, 1, 1);
      wb(0, `CAS_TIMER_OFS, 0);
      chk(rdat, 32'h190, 32'h190);
      wb(1, `CAS_CTRL_OFS, 32'h80);
      chk(pdn, 0, 0);
    end
  endtask

  // reset, then scenarios in order
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_hw;
    t_sw;
    t_warm;
    t_early;
    t_flags;
    t_pdn;
    test_done;
  end
endmodule // cas_sequencer_tb

bind cas_sequencer cas_seq_properties u_prop (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .adr_i(adr_i), .ack_o(ack_o), .err_o(err_o),
  .activation_command_pin_i(activation_command_pin_i),
  .class_select_addr0_pin_i(class_select_addr0_pin_i),
  .host_reset_addr1_pin_i(host_reset_addr1_pin_i),
  .host_clock_addr2_pin_i(host_clock_addr2_pin_i), .power_fail_i(power_fail_i),
  .card_present_filtered_i(card_present_filtered_i),
  .card_supply_select_o(card_supply_select_o), .card_reset_pin_o(card_reset_pin_o),
  .line_link_disable_o(line_link_disable_o), .card_data_level_o(card_data_level_o),
  .powered_down_o(powered_down_o), .bus_addr_low_o(bus_addr_low_o));
